// File: logic/tpp_defs.vh
// Constants for the two-phase pulse-width timing and voltage-code decode block.
// Included by the block's single design file; holds definitions only.
`ifndef TPP_DEFS_VH
`define TPP_DEFS_VH

// Default cycle period in core clocks (200 MHz / 1 MHz switching rate)
`define TPP_PERIOD_DEF      16'h00C8
// Sub-cycle fractions of the period
`define TPP_HALF_DEN        2
`define TPP_OFF_DEN         3
`define TPP_SAMPLE_DEN      6
// Table select encodings
`define TPP_TBL_SIX         2'h0
`define TPP_TBL_FIVE_A      2'h1
`define TPP_TBL_FIVE_B      2'h2
// Reference levels in units of 0.0125 V
`define TPP_REF_OFF         8'h00
`define TPP_FIVE_A_BASE     8'h58
`define TPP_FIVE_B_BASE     8'h40
`define TPP_SIX_SPLIT       6'h14
`define TPP_SIX_LOW_TOP     8'h57
`define TPP_SIX_HIGH_TOP    8'h95
`define TPP_FIVE_TOP        5'h1E
// Balance filter shift (first-order low-pass)
`define TPP_FILT_SHIFT      3

`endif

// File: logic/tpp_pwm_core.v
// Two-phase pulse timing, current balance and voltage-code decode.
// Assumes comparator results and sampled currents arrive synchronous to i_mclk.
// Operation
// - Cycle starts when phase one is forced low
// - Phase two ends half a cycle later
// - Both phase-two pins high selects one channel
// - Pulse held low one third cycle minimum
// - After off-time, ramp crossing drives pulse high
// - High pulse stays until next termination event
// - Falling pulse: upper off, lower on
// - Rising pulse: lower off, upper on
// - Average sampled currents over active channels
// - Filter per-channel error, correct pulse width
// - Sample window opens one sixth after fall
// - Hold captured sample until next period
// - Channel-two sensing idle in single mode
// - Voltage code decodes to one reference level
// - Table select pin chooses code table
// - Second five-bit table: off, 0.800 to 1.550
// - Undriven code pins read as one
// - First five-bit table: off, 1.100 to 1.850
// - Six-bit table: two off codes, 12.5 mV steps
`include "tpp_defs.vh"
`timescale 1ns/10ps
`default_nettype none

module tpp_pwm_core #(
    parameter PERIOD = `TPP_PERIOD_DEF,
    parameter CW     = 16,
    parameter IW     = 12
) (
    // Clock and reset
    input  wire          i_mclk,
    input  wire          i_rst_n,
    // Phase-two strap pins, high when tied to the gate supply
    input  wire          i_phase_two_bias_pin,
    input  wire          i_phase_two_node_pin,
    // Ramp comparators: error amp output less correction is above ramp
    input  wire          i_ramp_cross_one,
    input  wire          i_ramp_cross_two,
    // Sense current inputs
    input  wire [IW-1:0] i_sense_current_one,
    input  wire [IW-1:0] i_sense_current_two,
    // Voltage code pins (internal pull-up: a floating pin is driven 1 by the pad)
    input  wire [5:0]    i_voltage_code_pins,
    input  wire [1:0]    i_table_select_pin,
    // Pulses and gate drives
    output reg           o_phase_one_pulse,
    output reg           o_phase_two_pulse,
    output reg           o_upper_gate_one,
    output reg           o_lower_gate_one,
    output reg           o_upper_gate_two,
    output reg           o_lower_gate_two,
    // Sampling and balance
    output reg           o_sample_window_one,
    output reg           o_sample_window_two,
    output reg  [IW-1:0] o_cycle_average_current,
    output reg  [IW:0]   o_balance_correction_one,
    output reg  [IW:0]   o_balance_correction_two,
    // Status and reference
    output reg           o_single_channel,
    output reg  [7:0]    o_reference_level,
    output reg           o_output_off
);

    localparam [CW-1:0] HALF_CNT = PERIOD / `TPP_HALF_DEN;
    localparam [CW-1:0] OFF_CNT  = PERIOD / `TPP_OFF_DEN + ((PERIOD % `TPP_OFF_DEN) != 0);
    localparam [CW-1:0] SMP_CNT  = PERIOD / `TPP_SAMPLE_DEN;
    localparam [CW-1:0] LAST_CNT = PERIOD - 1;

    reg          rst_s1_r;
    reg          rst_s2_r;
    wire         rst_n = rst_s2_r;
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    // Cycle counter; both termination points (full and half period) are derived from it
    reg [CW-1:0] cnt_r;
    wire         term_one = (cnt_r == LAST_CNT);
    wire         term_two = (cnt_r == HALF_CNT - 1'b1);
    always @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n)
            cnt_r <= {CW{1'b0}};
        else if (term_one)
            cnt_r <= {CW{1'b0}};
        else
            cnt_r <= cnt_r + 1'b1;
    end

    // Straps are sampled every cycle so a change takes effect at once
    wire single_nxt = i_phase_two_bias_pin & i_phase_two_node_pin;

    // Counts since each pulse fell
    reg [CW-1:0] off_one_r;
    reg [CW-1:0] off_two_r;

    function [CW-1:0] off_step;
        input          fall;
        input          pulse;
        input [CW-1:0] cnt;
        begin
            if (fall)
                off_step = {CW{1'b0}};
            else if (!pulse && cnt != {CW{1'b1}})
                off_step = cnt + 1'b1;
            else
                off_step = cnt;
        end
    endfunction

    wire en_one = (off_one_r >= OFF_CNT - 1'b1);
    wire en_two = (off_two_r >= OFF_CNT - 1'b1);
    wire act_two = ~single_nxt;

    always @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_phase_one_pulse <= 1'b0;
            o_phase_two_pulse <= 1'b0;
            off_one_r         <= {CW{1'b0}};
            off_two_r         <= {CW{1'b0}};
            o_single_channel  <= 1'b0;
        end else begin
            o_single_channel <= single_nxt;
            off_one_r <= off_step(term_one, o_phase_one_pulse, off_one_r);
            off_two_r <= off_step(term_two | ~act_two, o_phase_two_pulse, off_two_r);
            if (term_one)
                o_phase_one_pulse <= 1'b0;
            else if (!o_phase_one_pulse && en_one && i_ramp_cross_one)
                o_phase_one_pulse <= 1'b1;
            if (term_two || !act_two)
                o_phase_two_pulse <= 1'b0;
            else if (!o_phase_two_pulse && en_two && i_ramp_cross_two)
                o_phase_two_pulse <= 1'b1;
        end
    end

    // Gate drives follow the pulses; break-before-make lives in the analog driver
    always @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_upper_gate_one <= 1'b0;
            o_lower_gate_one <= 1'b0;
            o_upper_gate_two <= 1'b0;
            o_lower_gate_two <= 1'b0;
        end else begin
            o_upper_gate_one <= o_phase_one_pulse;
            o_lower_gate_one <= ~o_phase_one_pulse;
            o_upper_gate_two <= o_phase_two_pulse & act_two;
            o_lower_gate_two <= ~o_phase_two_pulse & act_two;
        end
    end

    // Sample windows and held samples
    reg [IW-1:0] held_one_r;
    reg [IW-1:0] held_two_r;
    reg          upd_r;
    // Window register lags by one edge, so compare one count early
    wire win_one = ~o_phase_one_pulse & (off_one_r >= SMP_CNT - 1'b1);
    wire win_two = ~o_phase_two_pulse & (off_two_r >= SMP_CNT - 1'b1) & act_two;
    wire rise_one = ~o_phase_one_pulse & en_one & i_ramp_cross_one & ~term_one;
    wire rise_two = ~o_phase_two_pulse & en_two & i_ramp_cross_two & ~term_two & act_two;

    always @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_sample_window_one <= 1'b0;
            o_sample_window_two <= 1'b0;
            held_one_r          <= {IW{1'b0}};
            held_two_r          <= {IW{1'b0}};
            upd_r               <= 1'b0;
        end else begin
            o_sample_window_one <= win_one & ~rise_one;
            o_sample_window_two <= win_two & ~rise_two;
            upd_r <= term_one;
            // Capture at window close; held until the next close
            if (o_sample_window_one && (rise_one || o_phase_one_pulse || term_one))
                held_one_r <= i_sense_current_one;
            if (!act_two)
                held_two_r <= {IW{1'b0}};
            else if (o_sample_window_two && (rise_two || o_phase_two_pulse || term_two))
                held_two_r <= i_sense_current_two;
        end
    end

    // Balance: average once per cycle, then low-pass each channel's error
    wire [IW:0]   sum   = {1'b0, held_one_r} + {1'b0, held_two_r};
    wire [IW-1:0] avg   = act_two ? sum[IW:1] : held_one_r;
    wire [IW:0]   err_1 = {1'b0, avg} - {1'b0, held_one_r};
    wire [IW:0]   err_2 = {1'b0, avg} - {1'b0, held_two_r};

    function [IW:0] filt;
        input [IW:0] acc;
        input [IW:0] err;
        reg   [IW:0] dif;
        begin
            // Sign is extended by hand: an unsigned sum would turn the shift logical
            dif  = err - acc;
            filt = acc + {{`TPP_FILT_SHIFT{dif[IW]}}, dif[IW:`TPP_FILT_SHIFT]};
        end
    endfunction

    always @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_cycle_average_current  <= {IW{1'b0}};
            o_balance_correction_one <= {(IW+1){1'b0}};
            o_balance_correction_two <= {(IW+1){1'b0}};
        end else if (upd_r) begin
            o_cycle_average_current  <= avg;
            o_balance_correction_one <= filt(o_balance_correction_one, err_1);
            if (act_two)
                o_balance_correction_two <= filt(o_balance_correction_two, err_2);
            else
                o_balance_correction_two <= {(IW+1){1'b0}};
        end
    end

    // Voltage code decode, levels in 12.5 mV units
    reg [7:0] ref_nxt;
    reg       off_nxt;
    wire [4:0] c5 = i_voltage_code_pins[4:0];
    wire [5:0] c6 = {i_voltage_code_pins[4:0], i_voltage_code_pins[5]};
    always @* begin
        ref_nxt = `TPP_REF_OFF;
        off_nxt = 1'b0;
        case (i_table_select_pin)
            `TPP_TBL_FIVE_A: begin
                if (&c5)
                    off_nxt = 1'b1;
                else
                    ref_nxt = `TPP_FIVE_A_BASE + {2'b00, `TPP_FIVE_TOP - c5, 1'b0};
            end
            `TPP_TBL_FIVE_B: begin
                if (&c5)
                    off_nxt = 1'b1;
                else
                    ref_nxt = `TPP_FIVE_B_BASE + {2'b00, `TPP_FIVE_TOP - c5, 1'b0};
            end
            default: begin
                if (&c6[5:1])
                    off_nxt = 1'b1;
                else if (c6 > `TPP_SIX_SPLIT)
                    ref_nxt = `TPP_SIX_HIGH_TOP - {2'b00, c6};
                else
                    ref_nxt = `TPP_SIX_LOW_TOP - {2'b00, c6};
            end
        endcase
    end

    always @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_reference_level <= `TPP_REF_OFF;
            o_output_off      <= 1'b1;
        end else begin
            o_reference_level <= ref_nxt;
            o_output_off      <= off_nxt;
        end
    end

endmodule
`default_nettype wire

// File: verification/tpp_code_source.sv
// Processor side of the voltage-code pins and the table strap.
// Assumes a driven bit wins and an idle bit floats to the pad pull-up.
`timescale 1ns/10ps
`default_nettype none
module tpp_code_source (
    input  wire logic [5:0] i_code,
    input  wire logic [5:0] i_drive_en,
    input  wire logic [1:0] i_table,
    output logic      [5:0] o_pins,
    output logic      [1:0] o_table_select_pin
);
    // Enabled bits carry i_code, ones included; every idle bit rides on the weak pull-up
    assign o_pins = (i_code & i_drive_en) | ~i_drive_en;
    // Strap resistor already resolved to a table number
    assign o_table_select_pin = i_table;
endmodule
`default_nettype wire

// File: verification/tpp_pwm_core_props.sv
// Checker for pulse timing, gate order, sample window and decode.
// Assumes the bind below; off-time figures hold for PERIOD 24.
`timescale 1ns/10ps
`default_nettype none
module tpp_pwm_core_props #(parameter PERIOD = 24) (
    input wire logic       i_mclk,
    input wire logic       i_rst_n,
    input wire logic       i_phase_two_bias_pin,
    input wire logic       i_phase_two_node_pin,
    input wire logic [5:0] i_voltage_code_pins,
    input wire logic       o_phase_one_pulse,
    input wire logic       o_phase_two_pulse,
    input wire logic       o_upper_gate_one,
    input wire logic       o_lower_gate_one,
    input wire logic       o_lower_gate_two,
    input wire logic       o_sample_window_one,
    input wire logic       o_single_channel,
    input wire logic       o_output_off
);
    logic [2:0]  live_r;
    logic [15:0] ph_r;
    logic        seen_r;
    // Internal reset lags the pin by two edges, so arm late
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            live_r <= 3'h0;
            ph_r   <= 16'h0000;
            seen_r <= 1'b0;
        end else begin
            live_r <= {live_r[1:0], 1'b1};
            ph_r   <= $fell(o_phase_one_pulse) ? 16'h0001 : ph_r + 16'h0001;
            seen_r <= seen_r | $fell(o_phase_one_pulse);
        end
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!live_r[2]);
    property p_period; seen_r && $fell(o_phase_one_pulse) |-> ph_r % PERIOD == 0; endproperty
    a_period: assert property (p_period) else $error("phase one period wrong");
    property p_half; seen_r && $fell(o_phase_two_pulse) && !o_single_channel |-> ph_r % PERIOD == PERIOD / 2; endproperty
    a_half: assert property (p_half) else $error("phase two offset wrong");
    property p_off; $fell(o_phase_one_pulse) |-> !o_phase_one_pulse [*8]; endproperty
    a_off: assert property (p_off) else $error("forced off time cut short");
    property p_hold; seen_r && o_phase_one_pulse && ph_r % PERIOD != PERIOD - 1 |=> o_phase_one_pulse; endproperty
    a_hold: assert property (p_hold) else $error("pulse dropped early");
    property p_dn; $fell(o_phase_one_pulse) |=> o_lower_gate_one && !o_upper_gate_one; endproperty
    a_dn: assert property (p_dn) else $error("gates wrong after fall");
    property p_up; $rose(o_phase_one_pulse) |=> o_upper_gate_one && !o_lower_gate_one; endproperty
    a_up: assert property (p_up) else $error("gates wrong after rise");
    property p_win; $fell(o_phase_one_pulse) |-> !o_sample_window_one [*4] ##1 o_sample_window_one; endproperty
    a_win: assert property (p_win) else $error("sample window timing wrong");
    property p_single; (i_phase_two_bias_pin && i_phase_two_node_pin) ##1 o_single_channel |-> !o_phase_two_pulse && !o_lower_gate_two; endproperty
    a_single: assert property (p_single) else $error("channel two active in single mode");
    property p_codeoff; 1 |=> o_output_off == (($past(i_voltage_code_pins) | 6'h20) == 6'h3F); endproperty
    a_codeoff: assert property (p_codeoff) else $error("off code decode wrong");
    c_two: cover property ($fell(o_phase_two_pulse));
    c_single: cover property ($rose(o_single_channel));
    c_off: cover property ($rose(o_output_off));
endmodule
bind tpp_pwm_core tpp_pwm_core_props #(.PERIOD(PERIOD)) tpp_pwm_core_props_inst (.i_mclk, .i_rst_n,
    .i_phase_two_bias_pin, .i_phase_two_node_pin, .i_voltage_code_pins, .o_phase_one_pulse, .o_phase_two_pulse,
    .o_upper_gate_one, .o_lower_gate_one, .o_lower_gate_two, .o_sample_window_one, .o_single_channel, .o_output_off);
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for pulse timing, current balance and code decode.
// Assumes a short PERIOD of 24 core clocks.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int P = 24;
    logic        i_mclk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        bias = 1'b0, node = 1'b0, x1 = 1'b1, x2 = 1'b1;
    logic [11:0] c1 = 12'h0064, c2 = 12'h003C, avg;
    logic [5:0]  code = 6'h3F, en = 6'h00, pins;
    logic [1:0]  tbl = 2'h0, sel;
    logic        p1, p2, ug1, lg1, ug2, lg2, w1, w2, sgl, off;
    logic [12:0] k1, k2;
    logic [7:0]  lvl;
    logic [5:0]  cs [8] = '{6'h3F, 6'h1F, 6'h3E, 6'h1E, 6'h00, 6'h20, 6'h0A, 6'h2A};
    int          bad_count = 0, checks_done = 0, n;
    always #2.5 i_mclk = ~i_mclk;
    tpp_code_source tpp_code_source_inst (.i_code(code), .i_drive_en(en), .i_table(tbl), .o_pins(pins),
        .o_table_select_pin(sel));
    tpp_pwm_core #(.PERIOD(P)) tpp_pwm_core_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_phase_two_bias_pin(bias),
        .i_phase_two_node_pin(node), .i_ramp_cross_one(x1), .i_ramp_cross_two(x2), .i_sense_current_one(c1),
        .i_sense_current_two(c2), .i_voltage_code_pins(pins), .i_table_select_pin(sel), .o_phase_one_pulse(p1),
        .o_phase_two_pulse(p2), .o_upper_gate_one(ug1), .o_lower_gate_one(lg1), .o_upper_gate_two(ug2),
        .o_lower_gate_two(lg2), .o_sample_window_one(w1), .o_sample_window_two(w2), .o_cycle_average_current(avg),
        .o_balance_correction_one(k1), .o_balance_correction_two(k2), .o_single_channel(sgl),
        .o_reference_level(lvl), .o_output_off(off));
    task automatic tick(input int m);
        repeat (m) @(posedge i_mclk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("Checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Bounded wait for a pulse to rise and then fall; returns edges spent
    task automatic wait_fall(input bit two, output int m);
        m = 0;
        while (!(two ? p2 : p1) && m < 200) begin
            tick(1);
            m++;
        end
        while ((two ? p2 : p1) && m < 200) begin
            tick(1);
            m++;
        end
        if (m >= 200) begin
            bad_count++;
            final_report();
        end
    endtask
    // Expected {off, level} in 12.5 mV units; 0.025 V steps are two units
    function automatic logic [8:0] exp_ref(input int t, input logic [5:0] c);
        int v;
        v = {c[4:0], c[5]};
        if (c[4:0] == 5'h1F) return 9'h100;
        if (t == 1) return 9'(88 + 2 * (30 - int'(c[4:0])));
        if (t == 2) return 9'(64 + 2 * (30 - int'(c[4:0])));
        return 9'(v > 20 ? 149 - v : 87 - v);
    endfunction
    initial begin
        tick(12);
        i_rst_n = 1'b1;
        wait_fall(0, n);
        wait_fall(0, n);
        chk(16'(n), 16'(P));
        wait_fall(1, n);
        chk(16'(n), 16'(P / 2));
        tick(P / 6 - 1);
        chk(16'(w2), 16'h0000);
        tick(1);
        chk(16'(w2), 16'h0001);
        tick(4 * P);
        chk(16'(avg), 16'h0050);
        chk(16'(k1[12] ^ k2[12]), 16'h0001);
        chk(16'(|k1 && |k2), 16'h0001);
        c1 = 12'h00C8;
        tick(3 * P);
        chk(16'(avg), 16'h0082);
        $display("timing and balance test done");
        wait_fall(0, n);
        x1 = 1'b0;
        tick(P + P / 2);
        chk(16'(p1), 16'h0000);
        x1 = 1'b1;
        tick(2);
        chk(16'(p1), 16'h0001);
        $display("ramp crossing test done");
        wait_fall(1, n);
        bias = 1'b1;
        tick(3);
        chk(16'(sgl), 16'h0000);
        node = 1'b1;
        tick(3 * P);
        chk(16'(sgl), 16'h0001);
        chk(16'(avg), 16'h00C8);
        chk(16'({p2, ug2, lg2}), 16'h0000);
        bias = 1'b0;
        node = 1'b0;
        $display("single channel test done");
        foreach (cs[i]) begin
            for (int t = 0; t < 4; t++) begin
                tbl = t[1:0];
                code = cs[i];
                en = ~cs[i];
                tick(2);
                chk(16'({off, lvl}), 16'(exp_ref(t, cs[i])));
            end
        end
        $display("code decode test done");
        final_report();
    end
endmodule
`default_nettype wire
